// ---- crc_pkg.sv ----
package crc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0] REF_CONTROL_ADDR = 4'h0; // reference control
    localparam logic [3:0] REF_TAP_ADDR = 4'h1; // tap and pin status, read only
    localparam logic [7:0] REF_CONTROL_RESET = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POWER_BIT = 7;
    localparam int PIN_OE_BIT = 6;
    localparam int RANGE_BIT = 5;
    localparam int SOURCE_BIT = 4;
    localparam int LEVEL_MSB = 3;
    localparam int LEVEL_LSB = 0;
    localparam logic [4:0] LOW_RANGE_BASE = 5'h08; // quarter of 32 steps
    localparam logic [4:0] TAP_NONE = 5'h00;

    // ------------------------------------------------------------
    // decoded control
    // ------------------------------------------------------------
    typedef struct packed {
        logic power;
        logic pin_oe;
        logic range;
        logic source;
        logic [3:0] level;
    } crc_ctrl_t;

endpackage : crc_pkg

// ---- crc_tap_decode.sv ----
`timescale 1ns/100ps
// ------------------------------------------------------------
// ladder tap selection
// ------------------------------------------------------------
module crc_tap_decode
(
    // settings
    input wire crc_pkg::crc_ctrl_t ctrl,
    // ladder controls
    output logic [4:0] tap,
    output logic [1:0] step_denominator_sel
);

    // high range: code/24 from zero; low range: span/4 + code/32
    always_comb
    begin
        if (!ctrl.power)
        begin
            tap = crc_pkg::TAP_NONE;
        end
        else if (ctrl.range)
        begin
            tap = {1'b0, ctrl.level}; // RQ3 RQ5
        end
        else
        begin
            tap = 5'(crc_pkg::LOW_RANGE_BASE + {1'b0, ctrl.level}); // RQ3 RQ5
        end
        step_denominator_sel = {ctrl.power, ctrl.range};
    end

endmodule : crc_tap_decode

// ---- crc_ref_control.sv ----
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/100ps
// Operation
// RQ1: bit 7 powers the reference ladder on when one, off when zero.
// RQ2: bit 6 routes the reference onto the shared pin when one.
// RQ3: bit 5 picks range: one gives code/24 span, zero span/4 plus code/32.
// RQ4: bit 4 picks ladder supply: external reference pins or device rails.
// RQ5: bits 3 to 0 are an unsigned level code selecting one of sixteen taps.
// RQ6: device reset clears enable, pin enable, range and level code bits.
// RQ7: wake from Sleep leaves the control register unchanged.
// RQ8: pin driven only when pin enable and the direction bit are both one.
// RQ9: reference works whatever the comparator mode is.
// RQ10: software should disable the reference before entering Sleep.
// RQ11: all eight bits read and write, and all read zero after reset.
module crc_ref_control
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic CLK_EN,
    // register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // port pin direction bit, from the port logic on this clock
    input wire logic PIN_DIRECTION,
    // analog ladder controls
    output logic REF_POWER_ENABLE,
    output logic REF_SOURCE_SELECT,
    output logic REF_RANGE_SELECT,
    output logic [4:0] REF_LADDER_TAP,
    output logic REF_OUTPUT_PIN_OE
);

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    crc_pkg::crc_ctrl_t reference_control;
    crc_pkg::crc_ctrl_t next_reference_control;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic [4:0] tap;
    logic [1:0] step_sel;

    // control register address match, shared by the write decode and the checks
    function automatic logic is_control_addr(input logic [3:0] a);
        return a == crc_pkg::REF_CONTROL_ADDR;
    endfunction : is_control_addr

    // write decode; only reset or a write changes it, so sleep wake keeps it
    always_comb
    begin
        next_reference_control = reference_control; // RQ7
        if (WR && is_control_addr(ADDR))
        begin
            next_reference_control = crc_pkg::crc_ctrl_t'(WDATA); // RQ11
        end
    end

    // read mux, data one cycle after the read strobe
    always_comb
    begin
        next_rdata = 8'h00;
        if (RD)
        begin
            unique case (ADDR)
                crc_pkg::REF_CONTROL_ADDR: next_rdata = reference_control; // RQ11
                crc_pkg::REF_TAP_ADDR: next_rdata = {2'h0, REF_OUTPUT_PIN_OE, tap};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // registers
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            reference_control <= crc_pkg::REF_CONTROL_RESET; // RQ6 RQ11
            rdata <= 8'h00;
        end
        else if (CLK_EN)
        begin
            reference_control <= next_reference_control;
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // ladder and pin
    // ------------------------------------------------------------
    crc_tap_decode u_tap
    (
        .ctrl(reference_control),
        .tap(tap),
        .step_denominator_sel(step_sel)
    );

    // outputs, independent of any comparator mode
    assign RDATA = rdata;
    assign REF_POWER_ENABLE = reference_control.power; // RQ1 RQ9
    assign REF_SOURCE_SELECT = reference_control.source; // RQ4
    assign REF_RANGE_SELECT = step_sel[1] && step_sel[0]; // RQ3
    assign REF_LADDER_TAP = tap; // RQ5
    assign REF_OUTPUT_PIN_OE = reference_control.pin_oe && PIN_DIRECTION; // RQ2 RQ8

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // strobes that reach the control register while the clock runs
    sequence wr_ctl_s;
        WR && CLK_EN && is_control_addr(ADDR);
    endsequence

    sequence rd_ctl_s;
        RD && CLK_EN && !WR && is_control_addr(ADDR);
    endsequence

    // powered down leaves the ladder dark with no tap selected
    power_follows_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ1
        !reference_control.power
        |-> (!REF_POWER_ENABLE && REF_LADDER_TAP == crc_pkg::TAP_NONE))
        else $error("ladder power mismatch");

    // range select is held low while the ladder is off
    range_gate_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ3
        !REF_POWER_ENABLE |-> !REF_RANGE_SELECT)
        else $error("range select while powered down");

    // the power bit takes effect on the cycle after its write
    power_mode_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ9
        (wr_ctl_s and WDATA[crc_pkg::POWER_BIT]) |=> REF_POWER_ENABLE)
        else $error("power not applied after write");

    power_off_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ1
        (wr_ctl_s and !WDATA[crc_pkg::POWER_BIT]) |=> !REF_POWER_ENABLE)
        else $error("power not removed after write");

    // pin output needs the enable bit and the input direction
    pin_gate_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ8
        REF_OUTPUT_PIN_OE |-> (reference_control.pin_oe && PIN_DIRECTION))
        else $error("pin driven without both enables");

    pin_dir_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ8
        !PIN_DIRECTION |-> !REF_OUTPUT_PIN_OE)
        else $error("pin driven while direction is output");

    pin_enable_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ2
        ((wr_ctl_s and WDATA[crc_pkg::PIN_OE_BIT]) ##1 PIN_DIRECTION) |-> REF_OUTPUT_PIN_OE)
        else $error("pin not driven");

    pin_off_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ2
        !reference_control.pin_oe |-> !REF_OUTPUT_PIN_OE)
        else $error("pin driven with enable bit clear");

    // tap position in each range
    high_range_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ3
        (reference_control.power && reference_control.range)
        |-> tap == {1'b0, reference_control.level})
        else $error("high range tap wrong");

    low_range_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ5
        (reference_control.power && !reference_control.range)
        |-> tap == 5'(reference_control.level + crc_pkg::LOW_RANGE_BASE))
        else $error("low range tap wrong");

    // range, level and source fields land from the written byte
    range_write_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ3
        wr_ctl_s |=> reference_control.range == $past(WDATA[crc_pkg::RANGE_BIT]))
        else $error("range bit not written");

    level_write_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ5
        wr_ctl_s
        |=> reference_control.level == $past(WDATA[crc_pkg::LEVEL_MSB:crc_pkg::LEVEL_LSB]))
        else $error("level code not written");

    source_sel_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ4
        wr_ctl_s |=> REF_SOURCE_SELECT == $past(WDATA[crc_pkg::SOURCE_BIT]))
        else $error("source select mismatch");

    // reset clears the register and every output
    reset_clear_a: assert property (@(posedge REF_CLK) // RQ6
        RST |=> (reference_control == crc_pkg::REF_CONTROL_RESET))
        else $error("reset did not clear control");

    reset_outputs_a: assert property (@(posedge REF_CLK) // RQ6
        RST |=> (!REF_POWER_ENABLE && !REF_OUTPUT_PIN_OE && RDATA == '0
        && REF_LADDER_TAP == crc_pkg::TAP_NONE))
        else $error("reset did not clear outputs");

    // back to back write and read returns the written byte
    write_read_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ11
        (wr_ctl_s ##1 rd_ctl_s) |=> RDATA == $past(WDATA, 2))
        else $error("readback differs from write");

    // contents only change by a write, so a sleep wake keeps them
    hold_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ7
        (!RST && !(WR && is_control_addr(ADDR))) |=> $stable(reference_control))
        else $error("control changed without write");

    freeze_hold_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ7
        (!RST && !CLK_EN) |=> ($stable(reference_control) && $stable(RDATA)))
        else $error("state moved while clock enable low");

    // read data of unmapped, idle and status cycles
    unmapped_read_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ11
        (CLK_EN && RD && ADDR != crc_pkg::REF_CONTROL_ADDR && ADDR != crc_pkg::REF_TAP_ADDR)
        |=> RDATA == '0)
        else $error("unmapped read not zero");

    idle_rdata_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ11
        (CLK_EN && !RD) |=> RDATA == '0)
        else $error("read data without a read");

    tap_read_a: assert property (@(posedge REF_CLK) disable iff (RST) // RQ5
        (CLK_EN && RD && ADDR == crc_pkg::REF_TAP_ADDR)
        |=> RDATA == {2'h0, $past(REF_OUTPUT_PIN_OE), $past(REF_LADDER_TAP)})
        else $error("status read wrong");

endmodule : crc_ref_control

// ---- test_comparator_reference_control.sv ----
`timescale 1ns/100ps
module test_comparator_reference_control;
    // ----------------------------------------
    // bench signals
    // ----------------------------------------
    logic ref_clk, rst, clk_en, wr, rd, pin_direction;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    logic power, source, range_sel, pin_oe;
    logic [4:0] tap;
    int failures;
    int n_checks;

    crc_ref_control uut
    (
        .REF_CLK(ref_clk),
        .RST(rst),
        .CLK_EN(clk_en),
        .ADDR(addr),
        .WDATA(wdata),
        .WR(wr),
        .RD(rd),
        .RDATA(rdata),
        .PIN_DIRECTION(pin_direction),
        .REF_POWER_ENABLE(power),
        .REF_SOURCE_SELECT(source),
        .REF_RANGE_SELECT(range_sel),
        .REF_LADDER_TAP(tap),
        .REF_OUTPUT_PIN_OE(pin_oe)
    );

    // 25 MHz clock
    initial
    begin
        ref_clk = 1'h0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // compare, bus and report tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // outputs packed as power, source, range, tap, pin enable
    task automatic outs(input logic [8:0] e);
        chk("outputs", e, {power, source, range_sel, tap, pin_oe});
    endtask : outs

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge ref_clk);
        wr <= 1'h0;
        #1;
    endtask : wr_reg

    // read data is looked at in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge ref_clk);
        rd <= 1'h0;
        #1;
        chk("rdata", {1'h0, e}, {1'h0, rdata});
    endtask : rd_reg

    // write then read back on the very next cycle
    task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge ref_clk);
        wr <= 1'h0;
        rd <= 1'h1;
        @(posedge ref_clk);
        rd <= 1'h0;
        #1;
        chk("rdata", {1'h0, d}, {1'h0, rdata});
    endtask : wr_rd

    task automatic end_sim;
        if (failures == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        failures = 0;
        n_checks = 0;
        rst = 1'h1;
        clk_en = 1'h1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'h0;
        rd = 1'h0;
        pin_direction = 1'h1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'h0;
        #1;
        outs(9'h000);
        rd_reg(crc_pkg::REF_CONTROL_ADDR, 8'h00);
        wr_reg(crc_pkg::REF_CONTROL_ADDR, 8'hE5);
        outs({3'h5, 5'h05, 1'h1});
        rd_reg(crc_pkg::REF_CONTROL_ADDR, 8'hE5);
        rd_reg(crc_pkg::REF_TAP_ADDR, 8'h25);
        @(posedge ref_clk);
        pin_direction <= 1'h0;
        #1;
        outs({3'h5, 5'h05, 1'h0});
        wr_reg(crc_pkg::REF_CONTROL_ADDR, 8'h5A);
        outs({3'h2, 5'h00, 1'h0});
        @(posedge ref_clk);
        pin_direction <= 1'h1;
        #1;
        outs({3'h2, 5'h00, 1'h1});
        wr_reg(crc_pkg::REF_CONTROL_ADDR, 8'h8F);
        outs({3'h4, 5'h17, 1'h0});
        wr_reg(crc_pkg::REF_CONTROL_ADDR, 8'h90);
        outs({3'h6, 5'h08, 1'h0});
        wr_reg(crc_pkg::REF_CONTROL_ADDR, 8'hA0);
        outs({3'h5, 5'h00, 1'h0});
        wr_reg(4'h2, 8'hFF);
        rd_reg(crc_pkg::REF_CONTROL_ADDR, 8'hA0);
        rd_reg(4'h2, 8'h00);
        // power down before sleep, then a frozen clock enable holds the contents
        wr_rd(crc_pkg::REF_CONTROL_ADDR, 8'h20);
        outs(9'h000);
        @(posedge ref_clk);
        clk_en <= 1'h0;
        wr_reg(crc_pkg::REF_CONTROL_ADDR, 8'h3C);
        @(posedge ref_clk);
        clk_en <= 1'h1;
        rd_reg(crc_pkg::REF_CONTROL_ADDR, 8'h20);
        // reset in mid-run clears everything
        wr_reg(crc_pkg::REF_CONTROL_ADDR, 8'hFF);
        @(posedge ref_clk);
        rst <= 1'h1;
        @(posedge ref_clk);
        rst <= 1'h0;
        #1;
        outs(9'h000);
        rd_reg(crc_pkg::REF_CONTROL_ADDR, 8'h00);
        end_sim();
    end

    // hang guard
    initial
    begin
        repeat (2000) @(posedge ref_clk);
        failures++;
        end_sim();
    end
endmodule : test_comparator_reference_control
